/* File: sarad_ctrl.v */
// control logic of a ten-bit successive-approximation converter
// assumes an external DAC fed by DAC_CODE and a comparator answering on COMP_IN;
// every pin input but SRST is asynchronous to REF_CLK and is synchronised here; SRST is used directly
`include "sarad_defs.vh"
`default_nettype none

module sarad_ctrl (
  input  wire        REF_CLK,
  input  wire        SRST,
  input  wire        START,
  input  wire        COMP_IN,
  input  wire        BIPOLAR,
  input  wire        TWOS_SEL,
  input  wire        GRADE_SLOW,
  output reg         EOC,
  output reg  [9:0]  DATA,
  output reg         MSB_N,
  output reg         SER_OUT,
  output reg         CLK_OUT,
  output reg  [9:0]  DAC_CODE
);

  // ========================================================================
  // decision period per grade: the rate figure, shortened where the
  // conversion-time budget would otherwise be broken, but never below the
  // three cycles the synchronised comparator needs
  localparam integer BUDGET_FAST = (`SARAD_CONV_CYC_FAST - `SARAD_OVERHEAD_CYC) / `SARAD_NBITS;
  localparam integer BUDGET_SLOW = (`SARAD_CONV_CYC_SLOW - `SARAD_OVERHEAD_CYC) / `SARAD_NBITS;
  localparam integer PER_FAST_A  = (`SARAD_RATE_PER_FAST < BUDGET_FAST) ?
                                   `SARAD_RATE_PER_FAST : BUDGET_FAST;
  localparam integer PER_SLOW_A  = (`SARAD_RATE_PER_SLOW < BUDGET_SLOW) ?
                                   `SARAD_RATE_PER_SLOW : BUDGET_SLOW;
  localparam integer PER_FAST    = (PER_FAST_A < `SARAD_PER_MIN) ? `SARAD_PER_MIN : PER_FAST_A;
  localparam integer PER_SLOW    = (PER_SLOW_A < `SARAD_PER_MIN) ? `SARAD_PER_MIN : PER_SLOW_A;
  localparam integer LAST_FAST_I = PER_FAST - 1;
  localparam integer LAST_SLOW_I = PER_SLOW - 1;
  // the tick counter is four bits wide; periods stay well below sixteen cycles
  localparam [3:0]   LAST_FAST   = LAST_FAST_I[3:0];
  localparam [3:0]   LAST_SLOW   = LAST_SLOW_I[3:0];

  // ========================================================================
  // states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_RST  = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  // ========================================================================
  // input synchronisers: stage one feeds only stage two
  reg        start_s1_q;
  reg        start_s2_q;
  reg        comp_s1_q;
  reg        comp_s2_q;
  reg        bip_s1_q;
  reg        bip_s2_q;
  reg        twos_s1_q;
  reg        twos_s2_q;
  reg        slow_s1_q;
  reg        slow_s2_q;

  always @(posedge REF_CLK) begin
    if (SRST) begin
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      comp_s1_q  <= 1'b0;
      comp_s2_q  <= 1'b0;
      bip_s1_q   <= 1'b0;
      bip_s2_q   <= 1'b0;
      twos_s1_q  <= 1'b0;
      twos_s2_q  <= 1'b0;
      slow_s1_q  <= 1'b0;
      slow_s2_q  <= 1'b0;
    end else begin
      start_s1_q <= START;
      start_s2_q <= start_s1_q;
      comp_s1_q  <= COMP_IN;
      comp_s2_q  <= comp_s1_q;
      bip_s1_q   <= BIPOLAR;
      bip_s2_q   <= bip_s1_q;
      twos_s1_q  <= TWOS_SEL;
      twos_s2_q  <= twos_s1_q;
      slow_s1_q  <= GRADE_SLOW;
      slow_s2_q  <= slow_s1_q;
    end
  end

  // ========================================================================
  // sequencer state
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [3:0] tick_q;
  reg  [3:0] tick_d;
  reg  [3:0] bit_q;
  reg  [3:0] bit_d;
  reg  [9:0] sar_q;
  reg  [9:0] sar_d;
  reg  [3:0] last_tick_q;
  reg  [3:0] last_tick_d;

  wire       decide   = (state_q == ST_CONV) && (tick_q == last_tick_q);
  wire       last_bit = (bit_q == 4'h0);

  // one-hot mask of the bit under trial, one copy per bit position
  wire [9:0] trial_mask;
  wire [9:0] next_mask;
  genvar g;
  generate
    for (g = 0; g < `SARAD_NBITS; g = g + 1) begin : g_mask
      assign trial_mask[g] = (bit_q == g);
      assign next_mask[g]  = (bit_q == g + 1);
    end
  endgenerate

  // decided code: comparator high means the input is more negative than the
  // trial level, so the trial bit is kept and codes grow toward negative input
  wire [9:0] kept = comp_s2_q ? sar_q : (sar_q & ~trial_mask);

  always @* begin
    state_d     = state_q;
    tick_d      = tick_q;
    bit_d       = bit_q;
    sar_d       = sar_q;
    last_tick_d = last_tick_q;
    // start high overrides everything, even a conversion in flight
    if (start_s2_q) begin
      state_d = ST_RST;
      tick_d  = `SARAD_TICK_RST;
      bit_d   = `SARAD_MSB_IDX;
      sar_d   = `SARAD_DATA_RST;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_RST: begin
          // falling start edge: first trial is the MSB
          state_d     = ST_CONV;
          tick_d      = `SARAD_TICK_RST;
          bit_d       = `SARAD_MSB_IDX;
          sar_d       = `SARAD_FIRST_TRIAL;
          // grade is caught once per conversion so the period cannot shift
          last_tick_d = slow_s2_q ? LAST_SLOW : LAST_FAST;
        end
        ST_CONV: begin
          if (decide) begin
            tick_d = `SARAD_TICK_RST;
            if (last_bit) begin
              state_d = ST_IDLE;
              sar_d   = kept;
            end else begin
              bit_d = bit_q - 4'h1;
              sar_d = kept | next_mask;
            end
          end else begin
            tick_d = tick_q + 4'h1;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      state_q     <= ST_IDLE;
      tick_q      <= `SARAD_TICK_RST;
      bit_q       <= `SARAD_MSB_IDX;
      sar_q       <= `SARAD_DATA_RST;
      last_tick_q <= LAST_FAST;
    end else begin
      state_q     <= state_d;
      tick_q      <= tick_d;
      bit_q       <= bit_d;
      sar_q       <= sar_d;
      last_tick_q <= last_tick_d;
    end
  end

  // ========================================================================
  // outputs, all registered
  // two's complement only inverts the parallel MSB; serial never sees it
  wire       twos_on = bip_s2_q & twos_s2_q;
  wire       msb_new = kept[9];

  always @(posedge REF_CLK) begin
    if (SRST) begin
      EOC      <= 1'b0;
      DATA     <= `SARAD_DATA_RST;
      MSB_N    <= 1'b1;
      SER_OUT  <= 1'b0;
      CLK_OUT  <= 1'b0;
      DAC_CODE <= `SARAD_DATA_RST;
    end else begin
      DAC_CODE <= sar_d;
      // status falls in the same edge that lands the LSB decision
      EOC <= start_s2_q || (state_d != ST_IDLE);
      if (start_s2_q) begin
        // a new command clears the held result
        DATA    <= `SARAD_DATA_RST;
        MSB_N   <= 1'b1;
        SER_OUT <= 1'b0;
      end else if (decide) begin
        // each decision leaves on the serial line at the period boundary
        SER_OUT <= comp_s2_q;
        if (last_bit) begin
          DATA  <= {msb_new ^ twos_on, kept[8:0]};
          MSB_N <= ~msb_new;
        end
      end
      // one-cycle positive pulse one cycle into each period, so its rising
      // edge finds the previous decision already stable; none follows the LSB
      CLK_OUT <= (state_q == ST_CONV) && (tick_q == `SARAD_TICK_RST) &&
                 !start_s2_q;
    end
  end

endmodule

`default_nettype wire

/* File: sarad_defs.vh */
// constants for the ten-bit successive-approximation converter control logic
// assumes a single 40 MHz reference clock and an external DAC and comparator
// ==========================================================================
// How it works
// - start high holds reset; falling edge starts
// - status high in reset and conversion, then low
// - eleven parallel lines held until next start
// - serial NRZ decisions, MSB first, one per period
// - positive clock pulse train at grade rate; code pulses every 3 (fast) or 5 (slow) reference cycles
// - bipolar two's complement on parallel, by pin
// - unipolar straight binary on both outputs
// - ten bits, one decision per clock period
// - conversion within 800 ns or 1.4 us; fast grade takes 33 cycles (825 ns) from start fall
// - time from start rise to status fall
// - host captures previous bit; LSB lacks edge
`ifndef SARAD_DEFS_VH
`define SARAD_DEFS_VH

// ==========================================================================
// widths
`define SARAD_NBITS          10
`define SARAD_MSB_IDX        4'h9
`define SARAD_TICK_W         4

// ==========================================================================
// times, in their printed units
`define SARAD_REF_PERIOD_PS  25000
`define SARAD_START_MIN_NS   50
`define SARAD_RATE_FAST_KHZ  12500
`define SARAD_RATE_SLOW_KHZ  6600
`define SARAD_CONV_FAST_NS   800
`define SARAD_CONV_SLOW_NS   1400

// ==========================================================================
// derived cycle counts (longest times round down)
`define SARAD_RATE_PER_FAST  (1000000000 / `SARAD_RATE_FAST_KHZ / `SARAD_REF_PERIOD_PS)
`define SARAD_RATE_PER_SLOW  (1000000000 / `SARAD_RATE_SLOW_KHZ / `SARAD_REF_PERIOD_PS)
`define SARAD_CONV_CYC_FAST  (`SARAD_CONV_FAST_NS * 1000 / `SARAD_REF_PERIOD_PS)
`define SARAD_CONV_CYC_SLOW  (`SARAD_CONV_SLOW_NS * 1000 / `SARAD_REF_PERIOD_PS)
// cycles budgeted before the first decision period; the start path spends three: two sync stages plus state
`define SARAD_OVERHEAD_CYC   5
// the comparator path needs three cycles per decision
`define SARAD_PER_MIN        3

// ==========================================================================
// reset values
`define SARAD_DATA_RST       10'h000
// first trial code: only the MSB set
`define SARAD_FIRST_TRIAL    10'h200
`define SARAD_TICK_RST       4'h0

`endif

/* File: sarad_asserts.sv */
// checker of the converter control ports
// assumes it is bound onto sarad_ctrl
`default_nettype none
module sarad_asserts (
  input wire logic       REF_CLK,
  input wire logic       SRST,
  input wire logic       START,
  input wire logic       COMP_IN,
  input wire logic       BIPOLAR,
  input wire logic       TWOS_SEL,
  input wire logic       GRADE_SLOW,
  input wire logic       EOC,
  input wire logic [9:0] DATA,
  input wire logic       MSB_N,
  input wire logic       SER_OUT,
  input wire logic       CLK_OUT,
  input wire logic [9:0] DAC_CODE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // counters; a start pulse restarts both, so an aborted run does not leak pulses
  logic [3:0] pls_q;
  logic [5:0] run_q;
  always_ff @(posedge REF_CLK) begin
    pls_q <= (SRST || !EOC || START) ? 4'h0 : pls_q + {3'h0, CLK_OUT};
    run_q <= (SRST || !EOC || START) ? 6'h00 : run_q + 6'h01;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  AST_EOC_RST: assert property (START [*3] |=> EOC) else $error("status low in reset");
  AST_DATA_CLR: assert property (START [*3] |=> DATA == 10'h000)
    else $error("result kept in reset");
  AST_CLK_ONE: assert property (CLK_OUT |=> !CLK_OUT) else $error("clock pulse too long");
  AST_CLK_CONV: assert property (CLK_OUT |-> EOC) else $error("clock pulse when idle");
  AST_HOLD: assert property (!EOC && !START && !$past(START) && !$past(START, 2)
    |=> $stable(DATA) && $stable(MSB_N))
    else $error("result moved while idle");
  AST_CONV_TIME: assert property (run_q <= 6'h36) else $error("conversion too long");
  AST_PULSES: assert property ($fell(EOC) && !$past(SRST) |-> pls_q == 4'ha)
    else $error("wrong pulse count");
  AST_DAC_FIRST: assert property (CLK_OUT && pls_q == 4'h0 |-> DAC_CODE == 10'h200)
    else $error("first trial wrong");
  AST_SER_STEP: assert property ($changed(SER_OUT) && EOC && $past(EOC) && !$past(START, 3)
    |=> CLK_OUT)
    else $error("serial bit off its period");
  cover property ($fell(EOC));
  cover property (CLK_OUT && pls_q == 4'h9);
  cover property (START [*4]);
endmodule
bind sarad_ctrl sarad_asserts chk_u (.REF_CLK(REF_CLK), .SRST(SRST), .START(START),
  .COMP_IN(COMP_IN), .BIPOLAR(BIPOLAR), .TWOS_SEL(TWOS_SEL), .GRADE_SLOW(GRADE_SLOW),
  .EOC(EOC), .DATA(DATA), .MSB_N(MSB_N), .SER_OUT(SER_OUT), .CLK_OUT(CLK_OUT),
  .DAC_CODE(DAC_CODE));
`default_nettype wire

/* File: sarad_host.sv */
// host model: comparator stand-in and serial capture
// assumes the converter ports are wired straight to it
`default_nettype none
module sarad_host (
  input  wire logic       clk,
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] level,
  input  wire logic       clk_out,
  input  wire logic       ser_out,
  input  wire logic       eoc,
  output var  logic       comp,
  output var  logic [9:0] cap_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_out_q;
  logic eoc_q;
  // ==========================================================================
  // a higher level stands for a more negative input
  always_comb comp = (dac_code <= level);
  always_ff @(posedge clk) begin
    clk_out_q <= clk_out;
    eoc_q <= eoc;
    // the lsb has no clock edge, so the status fall captures it
    if ((clk_out && !clk_out_q) || (eoc_q && !eoc)) begin
      cap_q <= {cap_q[8:0], ser_out};
    end
  end
endmodule
`default_nettype wire

/* File: sarad_ctrl_tb.sv */
// self-checking bench of the converter control block
// assumes the block, host model and checker are compiled before it
`default_nettype none
module sarad_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, srst = 1'b1, start = 1'b0, bip = 1'b0, twos = 1'b0, slow = 1'b0;
  logic       comp, eoc, msb_n, ser, cko;
  logic [9:0] data, dac, cap, level = 10'h000;
  int         num_errors = 0, comparisons = 0, cycles = 0;
  always #12.5 clk = ~clk;
  sarad_ctrl dut_u (.REF_CLK(clk), .SRST(srst), .START(start), .COMP_IN(comp), .BIPOLAR(bip),
    .TWOS_SEL(twos), .GRADE_SLOW(slow), .EOC(eoc), .DATA(data), .MSB_N(msb_n),
    .SER_OUT(ser), .CLK_OUT(cko), .DAC_CODE(dac));
  sarad_host host_u (.clk(clk), .dac_code(dac), .level(level), .clk_out(cko), .ser_out(ser),
    .eoc(eoc), .comp(comp), .cap_q(cap));
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // ==========================================================================
  // one conversion with a start pulse w cycles wide
  task automatic convert(input logic [9:0] lv, input logic b, t, s, input int w);
    int n;
    level = lv; bip = b; twos = t; slow = s;
    step(3);
    start = 1'b1;
    step(w);
    if (w > 4) chk("cleared", data, 10'h000);
    start = 1'b0;
    step(1);
    chk("busy", {9'h000, eoc}, 10'h001);
    n = w + 1;
    while (eoc !== 1'b0 && n < 90) begin
      step(1);
      n++;
    end
    chk("time", 10'(n <= (s ? 56 : 36) + w - 2), 10'h001);
    step(1);
    chk("data", data, lv ^ {b & t, 9'h000});
    chk("msb_n", {9'h000, msb_n}, {9'h000, ~lv[9]});
    chk("serial", cap, lv);
    step(20);
    chk("held", data, lv ^ {b & t, 9'h000});
  endtask
  task automatic t_unipolar;
    logic [9:0] lvs [4] = '{10'h000, 10'h3ff, 10'h2a5, 10'h15a};
    for (int i = 0; i < 8; i++) convert(lvs[i % 4], 1'b0, 1'b0, i > 3, 2);
  endtask
  task automatic t_bipolar;
    convert(10'h1ff, 1'b1, 1'b0, 1'b0, 2);
    convert(10'h1ff, 1'b1, 1'b1, 1'b1, 2);
    convert(10'h200, 1'b1, 1'b1, 1'b0, 2);
  endtask
  task automatic t_long_start;
    convert(10'h0f0, 1'b0, 1'b0, 1'b1, 8);
  endtask
  // a start pulse during a conversion aborts it and the new result is exact
  task automatic t_abort;
    level = 10'h3c3;
    start = 1'b1;
    step(2);
    start = 1'b0;
    step(12);
    chk("aborted busy", {9'h000, eoc}, 10'h001);
    convert(10'h2c4, 1'b1, 1'b0, 1'b0, 2);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    step(5);
    srst = 1'b0;
    t_unipolar();
    t_bipolar();
    t_long_start();
    t_abort();
    stop_test();
  end
endmodule
`default_nettype wire
